// File: design/aclink_slot_pkg.sv
package aclink_slot_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W = 16;
  localparam int          DATA_W = 32;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] SLOT_FIFO_STATUS_OFS    = 16'hF750;
  localparam logic [15:0] DMA_REQUEST_STATUS_OFS  = 16'hF780;
  localparam logic [15:0] DMA_CHANNEL_MAPPING_OFS = 16'hF784;
  localparam logic [15:0] SLOT_CONTROL_OFS        = 16'hF790;
  localparam logic [15:0] EVENT_STATUS_OFS        = 16'hF794;
  localparam logic [15:0] EVENT_MASK_OFS          = 16'hF798;
  localparam logic [15:0] PCM_OUT_OFS             = 16'hF7A0;
  localparam logic [15:0] SURROUND_OUT_OFS        = 16'hF7A4;
  localparam logic [15:0] CENTER_OUT_OFS          = 16'hF7A8;
  localparam logic [15:0] LOW_FREQ_OUT_OFS        = 16'hF7AC;
  localparam logic [15:0] AUDIO_IN_OFS            = 16'hF7B0;
  localparam logic [15:0] MODEM_OUT_OFS           = 16'hF7B8;
  localparam logic [15:0] MODEM_IN_OFS            = 16'hF7BC;

  // ----------------------------------------------------------------
  // Streams: tx order pcm, surround, center, low_freq, modem
  // ----------------------------------------------------------------
  localparam int          NUM_TX = 5;
  localparam int          NUM_RX = 2;
  localparam int          PTR_W  = 3;
  localparam logic [3:0]  FIFO_FULL_COUNT = 4'h8;
  localparam logic [15:0] TX_DATA_OFS [NUM_TX] = '{PCM_OUT_OFS, SURROUND_OUT_OFS, CENTER_OUT_OFS,
                                                   LOW_FREQ_OUT_OFS, MODEM_OUT_OFS};
  localparam logic [15:0] RX_DATA_OFS [NUM_RX] = '{AUDIO_IN_OFS, MODEM_IN_OFS};

  // ----------------------------------------------------------------
  // Field positions (request, event and fill bits share one layout)
  // ----------------------------------------------------------------
  localparam int TX_FULL_BIT [NUM_TX] = '{8, 9, 10, 11, 14};
  localparam int TX_FILL_BIT [NUM_TX] = '{0, 1, 2, 3, 6};
  localparam int RX_FILL_BIT [NUM_RX] = '{4, 7};
  localparam int CTRL_DMA_ENABLE_BIT  = 0;
  localparam int CTRL_BIG_ENDIAN_BIT  = 1;

  // Streams served by a DMA channel, per mapping value
  localparam logic [7:0] MAP_MASK [4] = '{8'hD1, 8'hC3, 8'h0F, 8'h17};
  localparam logic [7:0] STREAM_BITS  = 8'hDF;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] MAPPING_RESET = 2'h0;
  localparam logic [1:0] CONTROL_RESET = 2'h0;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam int         SYNC_W        = 40;
  // Link bit clock period in the system, ns; sampling at mclk needs several samples per half period
  localparam int         LINK_PERIOD_NS = 400;
  localparam int         MCLK_PERIOD_NS = 50;
  localparam int         LINK_HALF_CYCLES = (LINK_PERIOD_NS / 2) / MCLK_PERIOD_NS;

endpackage

// File: design/aclink_fifo_dma_data_regs.sv
`timescale 1ns/1ps
// What this block does
// (R1) Status bit 14 shows modem tx full
// (R2) Bits 11..8 show lfe/center/surround/pcm full
// (R3) Status bit 7 shows modem rx nonempty
// (R4) Status bit 4 shows audio rx nonempty
// (R5) Bits 6,3..0 show tx FIFOs nonempty
// (R6) Request status word shows pending DMA requests
// (R7) Data register access clears stale request
// (R8) Mapping 0: pcm, audio in, modem
// (R9) Mapping 1: pcm, surround, modem
// (R10) Mapping 2: pcm, surround, center, lfe
// (R11) Mapping 3: pcm, surround, center, audio in
// (R12) Software idles requests before remapping
// (R13) Pcm/surround halves follow endian mode
// (R14) Center/lfe/modem halves follow endian mode
// (R15) Data write pushes pair, updates flags
module aclink_fifo_dma_data_regs
  import aclink_slot_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              link_bit_clk,
  input  wire logic [NUM_TX-1:0] tx_take,
  output logic [15:0]            tx_first_sample  [NUM_TX],
  output logic [15:0]            tx_second_sample [NUM_TX],
  input  wire logic [NUM_RX-1:0] rx_put,
  input  wire logic [15:0]       rx_first_sample,
  input  wire logic [15:0]       rx_second_sample,
  output logic [7:0]             dma_request,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Link-side synchroniser
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  logic              bclk_stable;
  logic              bclk_rise;
  logic [NUM_TX-1:0] take_s;
  logic [NUM_RX-1:0] put_s;
  logic [31:0]       rx_pair_s;

  // Strobes and data ride the same three stages as the clock so they stay aligned
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {rx_second_sample, rx_first_sample, rx_put, tx_take, link_bit_clk};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A clock level counts only once stages two and three agree
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bclk_stable <= 1'b0;
    end else if (sync2[0] == sync3[0]) begin
      bclk_stable <= sync3[0];
    end
  end

  assign bclk_rise = (sync2[0] == sync3[0]) && sync3[0] && !bclk_stable;
  assign take_s    = sync3[NUM_TX:1];
  assign put_s     = sync3[NUM_TX+NUM_RX:NUM_TX+1];
  assign rx_pair_s = sync3[SYNC_W-1:NUM_TX+NUM_RX+1];

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] aw_addr_q;
  logic              aw_held;
  logic [DATA_W-1:0] w_data_q;
  logic [3:0]        w_strb_q;
  logic              w_held;
  logic              wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic              wr_known;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign wr_addr       = {aw_addr_q[ADDR_W-1:2], 2'b00};

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      aw_held   <= 1'b0;
      aw_addr_q <= '0;
      w_held    <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [1:0] mapping;
  logic [1:0] control;
  logic [7:0] event_mask;
  logic [7:0] event_status;
  logic [7:0] event_set;
  logic       dma_enable;
  logic       big_endian;
  logic [7:0] mapped;

  assign dma_enable = control[CTRL_DMA_ENABLE_BIT];
  assign big_endian = control[CTRL_BIG_ENDIAN_BIT];
  assign mapped     = MAP_MASK[mapping]; // see (R8) (R9) (R10) (R11)

  // Remapping with requests pending is left to software
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mapping    <= MAPPING_RESET;
      control    <= CONTROL_RESET;
      event_mask <= MASK_RESET;
    end else if (wr_fire && w_strb_q[0]) begin
      if (wr_addr == DMA_CHANNEL_MAPPING_OFS) begin
        mapping <= w_data_q[1:0]; // see (R12)
      end else if (wr_addr == SLOT_CONTROL_OFS) begin
        control <= w_data_q[1:0];
      end else if (wr_addr == EVENT_MASK_OFS) begin
        event_mask <= w_data_q[7:0] & STREAM_BITS;
      end
    end
  end

  // Set wins over the write-one clear so no event is lost
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      event_status <= '0;
    end else if (wr_fire && w_strb_q[0] && wr_addr == EVENT_STATUS_OFS) begin
      event_status <= (event_status & ~w_data_q[7:0]) | event_set;
    end else begin
      event_status <= event_status | event_set;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(event_status & event_mask);
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] rd_addr;
  logic              rd_fire;
  logic [NUM_TX-1:0] wr_tx_sel;
  logic [NUM_TX-1:0] rd_tx_sel;
  logic [NUM_RX-1:0] rd_rx_sel;
  logic [31:0]       wr_pair;

  assign rd_addr       = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  // Halves are swapped once here, stored first sample in the low half
  assign wr_pair = big_endian ? {w_data_q[15:0], w_data_q[31:16]} : w_data_q; // see (R13) (R14)

  always_comb begin
    wr_tx_sel = '0;
    rd_tx_sel = '0;
    rd_rx_sel = '0;
    for (int i = 0; i < NUM_TX; i++) begin
      wr_tx_sel[i] = wr_fire && (wr_addr == TX_DATA_OFS[i]);
      rd_tx_sel[i] = rd_fire && (rd_addr == TX_DATA_OFS[i]);
    end
    for (int j = 0; j < NUM_RX; j++) begin
      rd_rx_sel[j] = rd_fire && (rd_addr == RX_DATA_OFS[j]);
    end
  end

  always_comb begin
    wr_known = 1'b1;
    if (wr_addr == SLOT_FIFO_STATUS_OFS || wr_addr == DMA_REQUEST_STATUS_OFS) begin
      wr_known = 1'b1;
    end else if (wr_addr == DMA_CHANNEL_MAPPING_OFS || wr_addr == SLOT_CONTROL_OFS) begin
      wr_known = 1'b1;
    end else if (wr_addr == EVENT_STATUS_OFS || wr_addr == EVENT_MASK_OFS) begin
      wr_known = 1'b1;
    end else if (|wr_tx_sel) begin
      wr_known = 1'b1;
    end else if (wr_addr == AUDIO_IN_OFS || wr_addr == MODEM_IN_OFS) begin
      wr_known = 1'b1;
    end else begin
      wr_known = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit FIFOs, one per output stream
  // ----------------------------------------------------------------
  logic [NUM_TX-1:0] tx_full;
  logic [NUM_TX-1:0] tx_nonempty;
  logic [NUM_TX-1:0] tx_underrun;

  for (genvar i = 0; i < NUM_TX; i++) begin : g_tx
    logic [31:0]      mem [2**PTR_W];
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [PTR_W:0]   count;
    logic             push;
    logic             pop;

    // A write into a full FIFO is dropped
    assign push           = wr_tx_sel[i] && !tx_full[i]; // see (R15)
    assign pop            = bclk_rise && take_s[i] && (count != '0);
    assign tx_full[i]     = (count == FIFO_FULL_COUNT);
    assign tx_nonempty[i] = (count != '0);
    assign tx_underrun[i] = bclk_rise && take_s[i] && (count == '0);

    always_ff @(posedge mclk) begin
      if (push) begin
        mem[wptr] <= wr_pair;
      end
    end

    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        wptr  <= '0;
        rptr  <= '0;
        count <= '0;
      end else begin
        if (push) begin
          wptr <= wptr + 1'b1;
        end
        if (pop) begin
          rptr <= rptr + 1'b1;
        end
        if (push && !pop) begin
          count <= count + 1'b1;
        end else if (pop && !push) begin
          count <= count - 1'b1;
        end
      end
    end

    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        tx_first_sample[i]  <= '0;
        tx_second_sample[i] <= '0;
      end else if (pop) begin
        tx_first_sample[i]  <= mem[rptr][15:0];
        tx_second_sample[i] <= mem[rptr][31:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive FIFOs, audio in and modem in
  // ----------------------------------------------------------------
  logic [NUM_RX-1:0] rx_nonempty;
  logic [NUM_RX-1:0] rx_overrun;
  logic [31:0]       rx_head [NUM_RX];

  for (genvar j = 0; j < NUM_RX; j++) begin : g_rx
    logic [31:0]      mem [2**PTR_W];
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [PTR_W:0]   count;
    logic             push;
    logic             pop;

    assign push           = bclk_rise && put_s[j] && (count != FIFO_FULL_COUNT);
    assign pop            = rd_rx_sel[j] && (count != '0);
    assign rx_nonempty[j] = (count != '0);
    assign rx_overrun[j]  = bclk_rise && put_s[j] && (count == FIFO_FULL_COUNT);
    assign rx_head[j]     = (count != '0) ? mem[rptr] : 32'h0000_0000;

    always_ff @(posedge mclk) begin
      if (push) begin
        mem[wptr] <= rx_pair_s;
      end
    end

    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        wptr  <= '0;
        rptr  <= '0;
        count <= '0;
      end else begin
        if (push) begin
          wptr <= wptr + 1'b1;
        end
        if (pop) begin
          rptr <= rptr + 1'b1;
        end
        if (push && !pop) begin
          count <= count + 1'b1;
        end else if (pop && !push) begin
          count <= count - 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Status words, DMA requests and events
  // ----------------------------------------------------------------
  logic [31:0] fifo_status;
  logic [7:0]  req_set;
  logic [7:0]  req_clear;
  logic [7:0]  pending;

  always_comb begin
    fifo_status = '0;
    req_set     = '0;
    req_clear   = '0;
    event_set   = '0;
    for (int i = 0; i < NUM_TX; i++) begin
      fifo_status[TX_FULL_BIT[i]] = tx_full[i];     // see (R1) (R2)
      fifo_status[TX_FILL_BIT[i]] = tx_nonempty[i]; // see (R5)
      req_set[TX_FILL_BIT[i]]     = dma_enable && mapped[TX_FILL_BIT[i]] && !tx_full[i];
      req_clear[TX_FILL_BIT[i]]   = wr_tx_sel[i] || rd_tx_sel[i]; // see (R7)
      event_set[TX_FILL_BIT[i]]   = tx_underrun[i];
    end
    for (int j = 0; j < NUM_RX; j++) begin
      fifo_status[RX_FILL_BIT[j]] = rx_nonempty[j]; // see (R3) (R4)
      req_set[RX_FILL_BIT[j]]     = dma_enable && mapped[RX_FILL_BIT[j]] && rx_nonempty[j];
      req_clear[RX_FILL_BIT[j]]   = rd_rx_sel[j]; // see (R7)
      event_set[RX_FILL_BIT[j]]   = rx_overrun[j];
    end
  end

  // Requests survive a DMA disable until software touches the data word
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pending <= '0;
    end else begin
      pending <= ((pending & ~req_clear) | req_set) & STREAM_BITS; // see (R6) (R7)
    end
  end

  assign dma_request = pending;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_value;
  logic [1:0]  rd_resp;

  always_comb begin
    rd_value = '0;
    rd_resp  = RESP_OKAY;
    if (rd_addr == SLOT_FIFO_STATUS_OFS) begin
      rd_value = fifo_status;
    end else if (rd_addr == DMA_REQUEST_STATUS_OFS) begin
      rd_value = {24'h00_0000, pending}; // see (R6)
    end else if (rd_addr == DMA_CHANNEL_MAPPING_OFS) begin
      rd_value = {30'h0000_0000, mapping};
    end else if (rd_addr == SLOT_CONTROL_OFS) begin
      rd_value = {30'h0000_0000, control};
    end else if (rd_addr == EVENT_STATUS_OFS) begin
      rd_value = {24'h00_0000, event_status};
    end else if (rd_addr == EVENT_MASK_OFS) begin
      rd_value = {24'h00_0000, event_mask};
    end else if (rd_addr == AUDIO_IN_OFS) begin
      rd_value = big_endian ? {rx_head[0][15:0], rx_head[0][31:16]} : rx_head[0];
    end else if (rd_addr == MODEM_IN_OFS) begin
      rd_value = big_endian ? {rx_head[1][15:0], rx_head[1][31:16]} : rx_head[1];
    end else if (|rd_tx_sel) begin
      rd_value = '0;
    end else begin
      rd_resp = RESP_SLVERR;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_value;
      s_axi_rresp  <= rd_resp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: tb/aclink_slot_props.sv
`timescale 1ns/1ps
module aclink_slot_props
  import aclink_slot_pkg::*;
(
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic [NUM_TX-1:0] tx_take,
  input wire logic [15:0]       tx_first_sample [NUM_TX],
  input wire logic [7:0]        dma_request
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Pin-level take age; the head may only move shortly after a take
  logic [3:0] since_take;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      since_take <= 4'hF;
    end else if (tx_take != '0) begin
      since_take <= 4'h0;
    end else if (since_take != 4'hF) begin
      since_take <= since_take + 4'h1;
    end
  end

  sequence s_rd(logic [15:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence

  property p_req_layout;
    dma_request[5] == 1'b0;
  endproperty
  a_req_layout: assert property (p_req_layout) else $error("reserved request bit set");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
  property p_unmapped;
    s_rd(16'h0000) |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_map_rd;
    s_rd(DMA_CHANNEL_MAPPING_OFS) |=> s_axi_rdata[31:2] == 30'h0;
  endproperty
  a_map_rd: assert property (p_map_rd) else $error("mapping upper bits set");
  property p_reqsts_rd;
    s_rd(DMA_REQUEST_STATUS_OFS) |=> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[5];
  endproperty
  a_reqsts_rd: assert property (p_reqsts_rd) else $error("request word reserved bits");
  property p_sts_rd;
    s_rd(SLOT_FIFO_STATUS_OFS) |=> (s_axi_rdata & 32'hFFFF_B020) == 32'h0;
  endproperty
  a_sts_rd: assert property (p_sts_rd) else $error("status word reserved bits");
  property p_tx_move;
    $changed(tx_first_sample[0]) |-> since_take < 4'hC;
  endproperty
  a_tx_move: assert property (p_tx_move) else $error("tx head moved without take");

  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  cover property (dma_request == 8'h91);
  cover property (tx_take != '0);
endmodule

bind aclink_fifo_dma_data_regs aclink_slot_props props (
  .mclk(mclk), .reset(reset), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .tx_take(tx_take), .tx_first_sample(tx_first_sample), .dma_request(dma_request)
);

// File: tb/codec_model.sv
`timescale 1ns/1ps
module codec_model
  import aclink_slot_pkg::*;
(
  output logic              link_bit_clk,
  output logic [NUM_TX-1:0] tx_take,
  output logic [NUM_RX-1:0] rx_put,
  output logic [15:0]       rx_first_sample,
  output logic [15:0]       rx_second_sample
);
  // Free-running bit clock, phase offset from mclk on purpose
  initial begin
    link_bit_clk = 1'b0;
    tx_take = '0;
    rx_put = '0;
    rx_first_sample = 16'hFFFF;
    rx_second_sample = 16'h0000;
    #13;
    forever #200 link_bit_clk = ~link_bit_clk;
  end

  task automatic take(input int s);
    @(negedge link_bit_clk);
    tx_take[s] <= 1'b1;
    @(negedge link_bit_clk);
    tx_take[s] <= 1'b0;
  endtask

  // Data held one full bit period, then scrambled so stale values never match
  task automatic put(input int s, input logic [15:0] a, input logic [15:0] b);
    @(negedge link_bit_clk);
    rx_put[s] <= 1'b1;
    rx_first_sample <= a;
    rx_second_sample <= b;
    @(negedge link_bit_clk);
    rx_put[s] <= 1'b0;
    rx_first_sample <= ~a;
    rx_second_sample <= ~b;
  endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb
  import aclink_slot_pkg::*;
;
  logic        mclk, reset, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, link_clk, irq;
  logic [15:0] awaddr, araddr, rx_a, rx_b;
  logic [31:0] wdata, rdata, d, v;
  logic [1:0]  bresp, rresp, r, put;
  logic [4:0]  take;
  logic [7:0]  dreq;
  logic [15:0] tx_a [NUM_TX];
  logic [15:0] tx_b [NUM_TX];
  int          fail_count = 0;
  int          total_checks = 0;
  int          fb [5] = '{0, 1, 2, 3, 6};
  // Rows: mapping value, expected requests with every FIFO empty
  localparam logic [9:0] rows [4] = '{10'h041, 10'h143, 10'h20F, 10'h307};

  aclink_fifo_dma_data_regs uut (
    .mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_bit_clk(link_clk), .tx_take(take),
    .tx_first_sample(tx_a), .tx_second_sample(tx_b), .rx_put(put), .rx_first_sample(rx_a),
    .rx_second_sample(rx_b), .dma_request(dreq), .irq(irq)
  );
  codec_model partner (
    .link_bit_clk(link_clk), .tx_take(take), .rx_put(put), .rx_first_sample(rx_a), .rx_second_sample(rx_b)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Handshakes judged at the rising edge where they happen, released right after it
  task automatic wr(input logic [15:0] a, input logic [31:0] dv, output logic [1:0] rv);
    @(posedge mclk);
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rv = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] dv, output logic [1:0] rv);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    dv = rdata;
    rv = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] dv;
    logic [1:0]  rv;
    rd(a, dv, rv);
    chk(dv, e);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    fail_count++;
    results();
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h0;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    rdc(SLOT_FIFO_STATUS_OFS, 32'h0);
    rdc(DMA_REQUEST_STATUS_OFS, 32'h0);
    rdc(DMA_CHANNEL_MAPPING_OFS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(SLOT_CONTROL_OFS, 32'h0, r);
      if (i > 0) chk(dreq, rows[i-1][7:0]);
      for (int s = 0; s < NUM_TX; s++) rd(TX_DATA_OFS[s], v, r);
      repeat (2) @(negedge mclk);
      chk(dreq, 8'h00);
      wr(DMA_CHANNEL_MAPPING_OFS, {30'h0, rows[i][9:8]}, r);
      rdc(DMA_CHANNEL_MAPPING_OFS, {30'h0, rows[i][9:8]});
      wr(SLOT_CONTROL_OFS, 32'h1, r);
      repeat (3) @(negedge mclk);
      chk(dreq, rows[i][7:0]);
      rdc(DMA_REQUEST_STATUS_OFS, {24'h0, rows[i][7:0]});
    end
    // Halves per stream and byte order, DMA off
    wr(SLOT_CONTROL_OFS, 32'h0, r);
    for (int s = 0; s < NUM_TX; s++) begin
      for (int be = 0; be < 2; be++) begin
        d = 32'hA5C3_0F1E + s * 32'h0111_0222 + be;
        wr(SLOT_CONTROL_OFS, be ? 32'h2 : 32'h0, r);
        wr(TX_DATA_OFS[s], d, r);
        rdc(SLOT_FIFO_STATUS_OFS, 32'h1 << fb[s]);
        partner.take(s);
        repeat (6) @(negedge mclk);
        chk(tx_a[s], be ? d[31:16] : d[15:0]);
        chk(tx_b[s], be ? d[15:0] : d[31:16]);
        rdc(SLOT_FIFO_STATUS_OFS, 32'h0);
      end
    end
    // Fill every transmit FIFO past full; the ninth pair is dropped
    wr(DMA_CHANNEL_MAPPING_OFS, 32'h2, r);
    wr(SLOT_CONTROL_OFS, 32'h1, r);
    for (int s = 0; s < NUM_TX; s++)
      for (int k = 0; k < 9; k++) wr(TX_DATA_OFS[s], 32'h100 * s + k, r);
    rdc(SLOT_FIFO_STATUS_OFS, 32'h4F4F);
    chk(dreq, 8'h00);
    for (int k = 0; k < 8; k++) begin
      partner.take(0);
      repeat (6) @(negedge mclk);
      chk(tx_a[0], k);
      if (k == 0) chk(dreq, 8'h01);
    end
    rdc(SLOT_FIFO_STATUS_OFS, 32'h4E4E);
    // Receive side, with pending request cleared before remapping
    wr(SLOT_CONTROL_OFS, 32'h0, r);
    rd(PCM_OUT_OFS, v, r);
    wr(DMA_CHANNEL_MAPPING_OFS, 32'h0, r);
    wr(SLOT_CONTROL_OFS, 32'h1, r);
    partner.put(0, 16'h1234, 16'hABCD);
    partner.put(1, 16'h5678, 16'hEF01);
    repeat (8) @(negedge mclk);
    rdc(SLOT_FIFO_STATUS_OFS, 32'h4EDE);
    chk(dreq, 8'h91);
    rdc(AUDIO_IN_OFS, 32'hABCD_1234);
    rdc(MODEM_IN_OFS, 32'hEF01_5678);
    rdc(SLOT_FIFO_STATUS_OFS, 32'h4E4E);
    // Underrun event, mask, clear; unmapped address
    partner.take(0);
    repeat (6) @(negedge mclk);
    chk(irq, 1'b0);
    wr(EVENT_MASK_OFS, 32'h1, r);
    repeat (3) @(negedge mclk);
    chk(irq, 1'b1);
    wr(EVENT_STATUS_OFS, 32'h1, r);
    repeat (3) @(negedge mclk);
    chk(irq, 1'b0);
    wr(16'h0000, 32'h1, r);
    chk(r, RESP_SLVERR);
    rd(16'h0000, v, r);
    chk(r, RESP_SLVERR);
    results();
  end
endmodule
